/* File: verilog/vcd_pkg.sv */
// Shared constants of the container demapper: register map, field layout,
// container geometry and the smoothing oscillator settings.
// Assumes a 200 MHz register clock and 32-bit APB.
package vcd_pkg;

	// Register byte offsets
	localparam logic [7:0] VCD_CTRL_ADDR    = 8'h00;
	localparam logic [7:0] VCD_STATUS_ADDR  = 8'h04;
	localparam logic [7:0] VCD_INT_ADDR     = 8'h08;
	localparam logic [7:0] VCD_MASK_ADDR    = 8'h0C;

	// Field positions
	localparam int VCD_CTRL_ACTIVE_BIT  = 0;
	localparam int VCD_ST_MISMATCH_BIT  = 0;
	localparam int VCD_ST_SRVFAIL_BIT   = 1;
	localparam int VCD_ST_TRLFAIL_BIT   = 2;
	localparam int VCD_ST_LABEL_LSB     = 4;
	localparam int VCD_ST_FILL_LSB      = 8;
	localparam int VCD_INT_BITS         = 4;
	localparam int VCD_INT_MISMATCH     = 0;
	localparam int VCD_INT_SRVFAIL      = 1;
	localparam int VCD_INT_LABEL        = 2;
	localparam int VCD_INT_SLIP         = 3;

	// Reset values
	localparam logic       VCD_CTRL_RESET  = 1'b0;
	localparam logic [3:0] VCD_MASK_RESET  = 4'h0;

	// Payload label
	localparam logic [2:0] VCD_EXPECTED_LABEL = 3'b010;
	localparam int         VCD_LABEL_PERSIST  = 5;

	// Container geometry: four quarters of 26 bytes, 8 bits each
	localparam int VCD_QUARTER_BYTES = 26;
	localparam int VCD_LABEL_FIRST   = 4;
	localparam int VCD_LABEL_LAST    = 6;
	localparam int VCD_C1_BIT        = 0;
	localparam int VCD_C2_BIT        = 1;
	localparam int VCD_IBIT_BIT      = 6;
	localparam int VCD_S1_BIT        = 6;
	localparam int VCD_S2_BIT        = 7;
	localparam int VCD_CVOTES_MAJ    = 2;

	// Tributary rate and smoothing oscillator
	localparam longint VCD_CLK_HZ       = 200000000;
	localparam longint VCD_TRIB_HZ      = 1544000;
	localparam logic [31:0] VCD_NCO_NOM =
		32'((2 * VCD_TRIB_HZ * (64'd1 << 32)) / VCD_CLK_HZ);
	localparam int VCD_NCO_GAIN_SHIFT   = 10;

	// Bit kinds inside the container
	typedef enum logic [2:0] {
		VCD_K_DATA, VCD_K_C1, VCD_K_C2, VCD_K_S1, VCD_K_S2,
		VCD_K_LABEL, VCD_K_SKIP
	} vcd_kind_e;

endpackage

/* File: verilog/vcd_bit_store.sv */
// Elastic store memory: one write port, one read port, registered read.
// Assumes both ports on the same clock; clock enable freezes it.
`timescale 1ns/10ps
module vcd_bit_store #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 64,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic             pclk,
	input  wire logic             ce,
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];  // Storage, no reset needed

	// Write and registered read
	always_ff @(posedge pclk) begin
		if (ce) begin
			if (wr_en) begin
				mem[wr_addr] <= wr_data;
			end
			rd_data <= mem[rd_addr];
		end
	end
endmodule // vcd_bit_store

/* File: verilog/vcd_demapper.sv */
// Container-to-tributary demapper: frames the gapped container stream,
// votes justification bits, fills an elastic store and plays it out on a
// smoothed clock, checks the payload label and inserts all-ONEs.
// Assumes link inputs are asynchronous to pclk and sampled here.
//
// How it works
// - Recover 1544 kbit/s tributary from container
// - Compare accepted label with 010, report it
// - Drop fixed-stuff and overhead bit positions
// - C1 majority zero makes S1 data
// - C2 majority zero makes S2 data
// - Write recovered bits on gapped input clock
// - Read out on smoothed clock tracking source
// - Store deep enough for 50 ppm offsets
// - Recover from frequency step in bounded time
// - Inactive drives all-ONEs, silences reports
// - Trail fail or mismatch forces AIS
// - Output clock stays nominal during AIS
// - Report mismatch only without trail fail
`timescale 1ns/10ps
module vcd_demapper
	import vcd_pkg::*;
#(
	parameter int DEPTH = 64
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic      [31:0] prdata,
	output logic             pslverr,
	input  wire logic        container_data_in,
	input  wire logic        container_clock_in,
	input  wire logic        container_frame_start_in,
	input  wire logic        trail_fail_in,
	output logic             tributary_data_out,
	output logic             tributary_clock_out,
	output logic             server_fail_out,
	output logic             irq
);
	import vcd_pkg::*;

	localparam int AW = $clog2(DEPTH);
	localparam logic [AW-1:0] HALF = AW'(DEPTH / 2);

	// Position classifier, used for every sampled bit
	function automatic vcd_kind_e classify(input logic [1:0] q,
			input logic [4:0] by, input logic [2:0] bi);
		vcd_kind_e k;
		k = VCD_K_SKIP;
		if (by == 5'd0) begin
			if (q == 2'd0 && bi >= 3'(VCD_LABEL_FIRST) && bi <= 3'(VCD_LABEL_LAST)) begin
				k = VCD_K_LABEL;
			end
		end else if (by == 5'd1) begin
			if (q != 2'd3) begin
				if (bi == 3'(VCD_C1_BIT))        k = VCD_K_C1;
				else if (bi == 3'(VCD_C2_BIT))   k = VCD_K_C2;
				else if (bi == 3'(VCD_IBIT_BIT)) k = VCD_K_DATA;
			end else begin
				if (bi == 3'(VCD_S1_BIT))        k = VCD_K_S1;
				else if (bi == 3'(VCD_S2_BIT))   k = VCD_K_S2;
			end
		end else begin
			k = VCD_K_DATA;
		end
		return k;
	endfunction

	// ---------------- Input synchronisers ----------------
	logic [3:0] pin_raw;    // Raw link pins
	logic [3:0] sync1;      // First stage, read only by sync2
	logic [3:0] sync2;      // Safe stage
	logic       clk_d;      // Delayed clock for edge find
	assign pin_raw = {trail_fail_in, container_frame_start_in,
		container_data_in, container_clock_in};

	// Two flops per pin before any logic
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_sync
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sync1[g] <= 1'b0;
					sync2[g] <= 1'b0;
				end else if (ce) begin
					sync1[g] <= pin_raw[g];
					sync2[g] <= sync1[g];
				end
			end
		end
	endgenerate

	wire link_rise = sync2[0] & ~clk_d;   // Sample point of container bit
	wire link_data = sync2[1];
	wire link_fs   = sync2[2];
	wire trail_fail_s = sync2[3];

	// ---------------- Control registers ----------------
	logic       function_active;   // Software activation
	logic [3:0] int_mask;          // Interrupt mask
	logic [3:0] int_status;        // Sticky events

	// ---------------- Container framing ----------------
	logic [1:0] qtr;        // Quarter of the multiframe
	logic [4:0] byte_cnt;   // Byte within quarter
	logic [2:0] bit_cnt;    // Bit within byte, MSB first
	logic [1:0] c1_ones;    // C1 votes for stuffing
	logic [1:0] c2_ones;    // C2 votes for stuffing
	logic [1:0] lab_sh;     // Label bits so far

	// Frame start forces position zero of the incoming bit
	wire [1:0] cur_q  = link_fs ? 2'd0 : qtr;
	wire [4:0] cur_by = link_fs ? 5'd0 : byte_cnt;
	wire [2:0] cur_bi = link_fs ? 3'd0 : bit_cnt;
	vcd_kind_e kind;
	assign kind = classify(cur_q, cur_by, cur_bi);

	wire c1_stuff = (c1_ones >= 2'(VCD_CVOTES_MAJ));
	wire c2_stuff = (c2_ones >= 2'(VCD_CVOTES_MAJ));
	// Only data and data-carrying opportunities enter the store
	wire take_bit = link_rise & ((kind == VCD_K_DATA) |
		((kind == VCD_K_S1) & ~c1_stuff) |
		((kind == VCD_K_S2) & ~c2_stuff));
	wire label_done = link_rise & (kind == VCD_K_LABEL) &
		(cur_bi == 3'(VCD_LABEL_LAST));
	wire [2:0] label_rx = {lab_sh, link_data};

	// Position counters and vote tallies
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_d    <= 1'b0;
			qtr      <= 2'd0;
			byte_cnt <= 5'd0;
			bit_cnt  <= 3'd0;
			c1_ones  <= 2'd0;
			c2_ones  <= 2'd0;
			lab_sh   <= 2'd0;
		end else if (ce) begin
			clk_d <= sync2[0];
			if (link_rise) begin
				bit_cnt <= cur_bi + 3'd1;
				qtr     <= cur_q;
				byte_cnt <= cur_by;
				// Step to next byte and quarter
				if (cur_bi == 3'd7) begin
					if (cur_by == 5'(VCD_QUARTER_BYTES - 1)) begin
						byte_cnt <= 5'd0;
						qtr      <= cur_q + 2'd1;
					end else begin
						byte_cnt <= cur_by + 5'd1;
					end
				end
				// Votes restart each frame
				if (link_fs) begin
					c1_ones <= 2'd0;
					c2_ones <= 2'd0;
				end else if (kind == VCD_K_C1 && link_data) begin
					c1_ones <= c1_ones + 2'd1;
				end else if (kind == VCD_K_C2 && link_data) begin
					c2_ones <= c2_ones + 2'd1;
				end
				if (kind == VCD_K_LABEL) begin
					lab_sh <= {lab_sh[0], link_data};
				end
			end
		end
	end

	// ---------------- Label acceptance ----------------
	logic [2:0] accepted_signal_label;  // Persistent label
	logic       label_valid;            // A label was accepted
	logic [2:0] last_label;             // Previous frame label
	logic [2:0] same_cnt;               // Identical frames seen

	// Accept after several identical frames
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			accepted_signal_label <= 3'b000;
			label_valid <= 1'b0;
			last_label  <= 3'b000;
			same_cnt    <= 3'd0;
		end else if (ce && label_done) begin
			last_label <= label_rx;
			if (label_rx != last_label) begin
				same_cnt <= 3'd1;
			end else if (same_cnt < 3'(VCD_LABEL_PERSIST)) begin
				same_cnt <= same_cnt + 3'd1;
			end
			if (label_rx == last_label &&
					same_cnt == 3'(VCD_LABEL_PERSIST - 1)) begin
				accepted_signal_label <= label_rx;
				label_valid <= 1'b1;
			end
		end
	end

	// Defect and consequent actions
	wire payload_mismatch_defect = label_valid &
		(accepted_signal_label != VCD_EXPECTED_LABEL);
	wire server_fail_action = trail_fail_s | payload_mismatch_defect;
	wire all_ones_insert_action = server_fail_action;
	wire payload_mismatch_report = payload_mismatch_defect & ~trail_fail_s &
		function_active;

	// ---------------- Elastic store ----------------
	logic [AW-1:0] wptr;      // Write pointer
	logic [AW-1:0] rptr;      // Read pointer
	logic          rd_bit;    // Registered store output
	wire  [AW-1:0] fill = wptr - rptr;
	// Near-empty or near-full means a slip; recentre rather than corrupt
	wire slip = (fill < AW'(2)) | (fill > AW'(DEPTH - 2));

	vcd_bit_store #(.WIDTH(1), .DEPTH(DEPTH)) u_store (
		.pclk    (pclk),
		.ce      (ce),
		.wr_en   (take_bit),
		.wr_addr (wptr),
		.wr_data (link_data),
		.rd_addr (rptr),
		.rd_data (rd_bit)
	);

	// Write pointer follows the gapped link clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wptr <= HALF;
		end else if (ce && take_bit) begin
			wptr <= wptr + AW'(1);
		end
	end

	// ---------------- Smoothed output clock ----------------
	logic [31:0] nco;         // Phase accumulator
	logic        nco_carry;   // Half-period tick
	// Fill error steers the rate so it follows the far-end source
	wire signed [AW:0]  fill_err = $signed({1'b0, fill}) - $signed({1'b0, HALF});
	wire signed [31:0]  nco_adj  = 32'(fill_err) <<< VCD_NCO_GAIN_SHIFT;
	// During AIS the rate is pinned to nominal
	wire [31:0] nco_inc = all_ones_insert_action ? VCD_NCO_NOM :
		VCD_NCO_NOM + 32'(nco_adj);
	wire [32:0] nco_sum = {1'b0, nco} + {1'b0, nco_inc};
	wire fall_tick = nco_carry & tributary_clock_out;

	// Oscillator, output clock and read pointer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nco <= 32'h0000_0000;
			nco_carry <= 1'b0;
			tributary_clock_out <= 1'b0;
			tributary_data_out <= 1'b1;
			rptr <= '0;
		end else if (ce) begin
			nco <= nco_sum[31:0];
			nco_carry <= nco_sum[32];
			if (nco_carry) begin
				tributary_clock_out <= ~tributary_clock_out;
			end
			// New bit leaves on the falling edge
			if (fall_tick) begin
				tributary_data_out <= (all_ones_insert_action | ~function_active) ?
					1'b1 : rd_bit;
				rptr <= slip ? (wptr - HALF) : (rptr + AW'(1));
			end
		end
	end

	// ---------------- Register bus ----------------
	wire setup    = psel & ~penable;
	wire access   = psel & penable & ~pready;
	wire hit_ctrl = (paddr == VCD_CTRL_ADDR);
	wire hit_stat = (paddr == VCD_STATUS_ADDR);
	wire hit_int  = (paddr == VCD_INT_ADDR);
	wire hit_mask = (paddr == VCD_MASK_ADDR);
	wire mapped   = hit_ctrl | hit_stat | hit_int | hit_mask;
	wire wr_go    = access & pwrite & mapped;
	wire rd_int   = access & ~pwrite & hit_int;

	// Status word, silenced while inactive
	wire [31:0] status_word = function_active ?
		(32'(payload_mismatch_report) << VCD_ST_MISMATCH_BIT) |
		(32'(server_fail_action) << VCD_ST_SRVFAIL_BIT) |
		(32'(trail_fail_s) << VCD_ST_TRLFAIL_BIT) |
		(32'(accepted_signal_label) << VCD_ST_LABEL_LSB) |
		(32'(fill) << VCD_ST_FILL_LSB) : 32'h0000_0000;

	wire [31:0] rd_mux = hit_ctrl ? 32'(function_active) :
		hit_stat ? status_word :
		hit_int  ? 32'(int_status) :
		hit_mask ? 32'(int_mask) : 32'h0000_0000;

	// Event edges for interrupts
	logic       prev_rep;    // Last mismatch report
	logic       prev_srv;    // Last server fail
	logic [2:0] prev_lab;    // Last accepted label
	wire [3:0] events = {fall_tick & slip,
		accepted_signal_label != prev_lab,
		server_fail_action & ~prev_srv,
		payload_mismatch_report & ~prev_rep} & {4{function_active}};

	// One wait state; defined error on unmapped addresses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			function_active <= VCD_CTRL_RESET;
			int_mask <= VCD_MASK_RESET;
		end else if (ce) begin
			pready  <= access;
			pslverr <= access & ~mapped;
			if (access && !pwrite) begin
				prdata <= rd_mux;
			end else if (setup) begin
				prdata <= 32'h0000_0000;
			end
			if (wr_go && hit_ctrl) begin
				function_active <= pwdata[VCD_CTRL_ACTIVE_BIT];
			end
			if (wr_go && hit_mask) begin
				int_mask <= pwdata[VCD_INT_BITS-1:0];
			end
		end
	end

	// Sticky events; read clears, a new event wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_status <= 4'h0;
			prev_rep <= 1'b0;
			prev_srv <= 1'b0;
			prev_lab <= 3'b000;
			irq <= 1'b0;
			server_fail_out <= 1'b0;
		end else if (ce) begin
			prev_rep <= payload_mismatch_report;
			prev_srv <= server_fail_action;
			prev_lab <= accepted_signal_label;
			int_status <= (rd_int ? 4'h0 : int_status) | events;
			irq <= |(int_status & int_mask);
			server_fail_out <= server_fail_action;
		end
	end
endmodule // vcd_demapper

/* File: dv/vcd_demapper_monitor.sv */
// Checker for the demapper pins: bus handshake, alarm, output clock.
// Bound onto every demapper instance; sees its ports only.
`timescale 1ns/10ps
module vcd_demapper_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic trail_fail_in,
	input wire logic tributary_data_out,
	input wire logic tributary_clock_out,
	input wire logic server_fail_out
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic       tck_d;    // Output clock one cycle ago
	logic       seen;     // A first clock edge has been seen
	logic [7:0] ph;       // Cycles since last clock edge
	logic [1:0] sf_bits;  // Output bits since alarm rose
	wire        tck_chg  = tck_d != tributary_clock_out;
	wire        tck_rise = tck_chg && tributary_clock_out;

	// Phase timer and alarm age; both saturate so they never wrap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tck_d   <= 1'b0;
			seen    <= 1'b0;
			ph      <= 8'h00;
			sf_bits <= 2'h0;
		end else begin
			tck_d   <= tributary_clock_out;
			seen    <= seen | tck_chg;
			ph      <= tck_chg ? 8'h01 : ph + 8'(ph != 8'hff);
			sf_bits <= !server_fail_out ? 2'h0 : sf_bits + 2'(tck_rise && sf_bits != 2'h3);
		end
	end

	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("ready held past one cycle");
	AST_SLVERR_WITH_READY: assert property (pslverr |-> pready)
		else $error("error flag without ready");
	AST_READY_AFTER_ACCESS: assert property (psel && $rose(penable) |=> pready)
		else $error("no answer one cycle into access");
	AST_READY_NEEDS_ACCESS: assert property (pready |-> $past(penable))
		else $error("answer without access phase");
	// Alarm age lags the alarm pin by one cycle, so gate on the pin too
	AST_AIS_ONES: assert property (server_fail_out && sf_bits >= 2'h2
			|-> tributary_data_out)
		else $error("data not all ones under alarm");
	AST_TRAIL_ALARM: assert property (trail_fail_in [*5] |-> server_fail_out)
		else $error("trail fail not passed on");
	AST_TCLK_RATE: assert property (seen && tck_chg |-> ph inside {[63:66]})
		else $error("output clock phase off rate");
	AST_AIS_NOMINAL: assert property (sf_bits == 2'h3 && tck_chg |-> ph inside {[64:65]})
		else $error("output clock not nominal under alarm");
endmodule // vcd_demapper_monitor

bind vcd_demapper vcd_demapper_monitor u_mon (.pclk, .presetn, .psel, .penable, .pready,
	.pslverr, .trail_fail_in, .tributary_data_out, .tributary_clock_out, .server_fail_out);

/* File: dv/vcd_container_src.sv */
// Path-side source: gapped link clock, container bits and frame start.
// Started by the bench through go; runs on its own 48 ns clock.
`timescale 1ns/10ps
module vcd_container_src (
	input wire logic       go,      // Start a burst
	input wire logic [2:0] frames,  // Frames in the burst
	input wire logic [2:0] label,   // Payload label sent
	input wire logic       c1,      // First control value
	input wire logic       c2,      // Second control value
	output logic           ck,      // Gapped link clock
	output logic           d,       // Container bit
	output logic           fs,      // Frame start
	output logic           busy     // Burst running
);
	// Bit i of a frame; unused spots are ones, except byte 0 of quarters 1 to 3 which is zero, so a leak there would not show
	function automatic logic bit_at(int i);
		int q;
		int b;
		int k;
		q = i / 208;
		b = (i % 208) / 8;
		k = i % 8;
		if (q == 0 && b == 0)
			return (k >= 4 && k <= 6) ? label[6-k] : 1'b1;
		// First control copy inverted: only a vote recovers the value
		// Bit 6 of this byte is a data bit and goes out as zero
		if (b == 1 && q < 3)
			return k == 0 ? c1 ^ (q == 0) : k == 1 ? c2 ^ (q == 0) : k != 6;
		// Opportunity bits: one when stuffed, else a zero data bit
		if (b == 1)
			return k == 6 ? c1 : k == 7 ? c2 : 1'b1;
		return 1'b0;
	endfunction

	// Clock stands still between bursts; data flips so it is never stale
	initial begin
		ck = 1'b0;
		d = 1'b0;
		fs = 1'b0;
		busy = 1'b0;
		forever begin
			while (!go) begin
				#24 d = ~d;
			end
			busy = 1'b1;
			repeat (frames) begin
				for (int i = 0; i < 832; i++) begin
					d = bit_at(i);
					fs = (i == 0);
					#24 ck = 1'b1;
					#24 ck = 1'b0;
				end
			end
			fs = 1'b0;
			busy = 1'b0;
			wait (!go);
		end
	end
endmodule // vcd_container_src

/* File: dv/vcd_demapper_tb.sv */
// Self-checking bench for the demapper: APB master, container source.
// Container data bits are all zero, so a leaked unused bit of the label byte or byte 1 reads as one.
`timescale 1ns/10ps
module vcd_demapper_tb;
	import vcd_pkg::*;

	logic        pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, v;
	logic        pready, pslverr, e, trail_fail_in = 1'b0, irq, server_fail_out;
	logic        container_data_in, container_clock_in, container_frame_start_in;
	logic        tributary_data_out, tributary_clock_out, busy;
	logic        go = 1'b0, c1 = 1'b0, c2 = 1'b0;
	logic [2:0]  frames = 3'h0, label = 3'h0;
	int          n_mismatch = 0;
	int          samples_checked = 0;

	vcd_demapper DUT (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .prdata, .pslverr, .container_data_in, .container_clock_in,
		.container_frame_start_in, .trail_fail_in, .tributary_data_out,
		.tributary_clock_out, .server_fail_out, .irq);
	vcd_container_src u_src (.go, .frames, .label, .c1, .c2, .ck(container_clock_in),
		.d(container_data_in), .fs(container_frame_start_in), .busy);

	// 200 MHz clock
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic got, input logic exp);
		chk({31'h0000_0000, got}, {31'h0000_0000, exp});
	endtask

	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		v = prdata;
		e = pslverr;
		if (n >= 50) n_mismatch++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Output bit at the next rising edge of the recovered clock
	task automatic tout(output logic b);
		int n;
		logic p;
		n = 0;
		do begin
			p = tributary_clock_out;
			@(posedge pclk);
			n++;
		end while (!(p === 1'b0 && tributary_clock_out === 1'b1) && n < 2000);
		if (n >= 2000) n_mismatch++;
		b = tributary_data_out;
	endtask
	// Skip the bit in flight, then judge two
	task automatic expect_out(input logic x);
		logic b;
		tout(b);
		repeat (2) begin
			tout(b);
			chk_pin(b, x);
		end
	endtask

	// Burst of frames from the source, bounded wait
	task automatic run_frames(input int n, input logic [2:0] lb, input logic [1:0] c);
		int k;
		frames <= n[2:0];
		label <= lb;
		{c1, c2} <= c;
		go <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (busy !== 1'b1 && k < 100);
		if (busy !== 1'b1) n_mismatch++;
		go <= 1'b0;
		do begin
			@(posedge pclk);
			k++;
		end while (busy !== 1'b0 && k < 9000 * n);
		if (k >= 9000 * n) n_mismatch++;
	endtask

	// Reset values, refusal, inactive output, then switch on
	task automatic t_regs;
		apb(1'b0, VCD_CTRL_ADDR, 32'h0000_0000);
		chk(v, 32'(VCD_CTRL_RESET));
		apb(1'b0, VCD_MASK_ADDR, 32'h0000_0000);
		chk(v, 32'(VCD_MASK_RESET));
		apb(1'b0, 8'h10, 32'h0000_0000);
		chk(v, 32'h0000_0000);
		chk_pin(e, 1'b1);
		apb(1'b1, VCD_MASK_ADDR, 32'h0000_000f);
		apb(1'b0, VCD_MASK_ADDR, 32'h0000_0000);
		chk(v, 32'h0000_000f);
		expect_out(1'b1);
		apb(1'b0, VCD_STATUS_ADDR, 32'h0000_0000);
		chk(v, 32'h0000_0000);
		apb(1'b1, VCD_MASK_ADDR, 32'h0000_0001);
		apb(1'b1, VCD_CTRL_ADDR, 32'h0000_0001);
		apb(1'b0, VCD_CTRL_ADDR, 32'h0000_0000);
		chk(v, 32'h0000_0001);
	endtask

	// Wrong label accepted: alarm, interrupt, trail fail hides report
	task automatic t_mismatch;
		run_frames(5, 3'h5, 2'h3);
		chk_pin(irq, 1'b1);
		chk_pin(server_fail_out, 1'b1);
		apb(1'b0, VCD_STATUS_ADDR, 32'h0000_0000);
		chk(v & 32'h0000_0077, 32'h0000_0053);
		expect_out(1'b1);
		apb(1'b0, VCD_INT_ADDR, 32'h0000_0000);
		chk(v & 32'h0000_0001, 32'h0000_0001);
		repeat (3) @(posedge pclk);
		chk_pin(irq, 1'b0);
		trail_fail_in <= 1'b1;
		repeat (10) @(posedge pclk);
		apb(1'b0, VCD_STATUS_ADDR, 32'h0000_0000);
		chk(v & 32'h0000_0007, 32'h0000_0006);
		trail_fail_in <= 1'b0;
		apb(1'b1, VCD_MASK_ADDR, 32'h0000_0000);
	endtask

	// Right label over every control code; clean data, trail alarm masked
	task automatic t_good;
		for (int i = 0; i < 4; i++) run_frames(1, 3'h2, 2'(i));
		fork
			run_frames(1, 3'h2, 2'h3);
			begin
				repeat (300) @(posedge pclk);
				expect_out(1'b0);
				trail_fail_in <= 1'b1;
				expect_out(1'b1);
				chk_pin(server_fail_out, 1'b1);
				chk_pin(irq, 1'b0);
				trail_fail_in <= 1'b0;
				expect_out(1'b0);
			end
		join
		chk_pin(server_fail_out, 1'b0);
		apb(1'b0, VCD_STATUS_ADDR, 32'h0000_0000);
		chk(v & 32'h0000_0077, 32'h0000_0020);
		apb(1'b0, VCD_INT_ADDR, 32'h0000_0000);
		chk(v & 32'h0000_0002, 32'h0000_0002);
	endtask

	// Switched off: all ones and silent status
	task automatic t_off;
		apb(1'b1, VCD_CTRL_ADDR, 32'h0000_0000);
		expect_out(1'b1);
		apb(1'b0, VCD_STATUS_ADDR, 32'h0000_0000);
		chk(v, 32'h0000_0000);
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Hang guard: expected run is about 81 000 cycles, guard fires at 95 000
	initial begin
		#475000;
		n_mismatch++;
		test_done;
	end

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_mismatch;
		t_good;
		t_off;
		test_done;
	end
endmodule // vcd_demapper_tb
